/* src/oscc_pkg.sv */
// Shared constants and types of the on/off switching-cycle controller.
// Assumes a 50 MHz reference clock; every clock-cycle count below is derived from it.
package oscc_pkg;

    // Clock and oscillator.
    localparam int unsigned CLK_HZ = 50_000_000;
    localparam int unsigned OSC_HZ = 132_000;
    localparam int unsigned JIT_PP_HZ = 8_000;
    localparam int unsigned OSC_PERIOD_CYC = CLK_HZ / OSC_HZ;
    localparam int unsigned OSC_FAST_CYC = CLK_HZ / (OSC_HZ + JIT_PP_HZ / 2);
    localparam int unsigned JIT_CYC = 2 * (OSC_PERIOD_CYC - OSC_FAST_CYC);
    localparam int unsigned MAX_DUTY_PCT = 65;
    localparam int unsigned DUTY_CYC = OSC_PERIOD_CYC * MAX_DUTY_PCT / 100;

    // Shortest conduction before the frequency is lowered.
    localparam int unsigned MIN_ON_NS = 400;
    localparam int unsigned MIN_ON_CYC = (MIN_ON_NS * (CLK_HZ / 1_000_000) + 999) / 1000;

    // Fault and restart-off intervals, counted in oscillator cycles.
    localparam int unsigned FAULT_MS = 64;
    localparam int unsigned RESTART_MS = 2500;
    localparam int unsigned FAULT_OSC = FAULT_MS * (OSC_HZ / 1000);
    localparam int unsigned RESTART_OSC = RESTART_MS * (OSC_HZ / 1000);

    // Current-limit state machine window and thresholds.
    localparam int unsigned CL_WIN = 16;
    localparam int unsigned CL_FULL_MIN = 8;
    localparam int unsigned CL_MED_MIN = 3;

    // Register map.
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_STATUS = 8'h04;
    localparam logic [7:0] REG_COUNT = 8'h08;
    localparam logic [1:0] CTRL_RESET = 2'h3;
    localparam int unsigned CTRL_RUN_BIT = 0;
    localparam int unsigned CTRL_JIT_BIT = 1;

    // Supply-capacitor classes and current-limit ranges.
    localparam logic [1:0] CAP_MIN = 2'h0;
    localparam logic [1:0] CAP_MED = 2'h1;
    localparam logic [1:0] CAP_LARGE = 2'h2;
    localparam logic [1:0] RNG_STD = 2'h0;
    localparam logic [1:0] RNG_RED = 2'h1;
    localparam logic [1:0] RNG_INC = 2'h2;

    typedef enum logic [2:0] {
        ST_UV_WAIT = 3'h1,
        ST_RUN = 3'h2,
        ST_OFF = 3'h4
    } oscc_run_t;

    typedef enum logic [2:0] {
        CL_FULL = 3'h1,
        CL_MED = 3'h2,
        CL_LIGHT = 3'h4
    } oscc_cl_t;

    typedef struct packed {
        logic start;
        logic max_duty;
    } oscc_osc_t;

endpackage : oscc_pkg

/* src/oscc_interval_timer.sv */
// Interval counter advanced by oscillator ticks.
// Assumes the tick is a one-cycle pulse in the reference clock domain.
`timescale 1ns/1ns
`default_nettype none
module oscc_interval_timer #(
    parameter int unsigned LIMIT = 8448,
    parameter int unsigned W = $clog2(LIMIT + 1)
) (
    // Clock and reset.
    input wire logic i_ref_clk,
    input wire logic i_rst_n,
    input wire logic i_clk_en,
    // Control.
    input wire logic i_clear,
    input wire logic i_tick,
    // Status.
    output logic o_done
);
    logic [W-1:0] cnt_q;
    logic [W-1:0] cnt_d;

    always_comb begin
        cnt_d = cnt_q;
        if (i_clear) begin
            cnt_d = '0;
        end else if (i_tick && cnt_q != W'(LIMIT)) begin
            cnt_d = cnt_q + 1'b1;
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_n) begin
            cnt_q <= '0;
        end else if (i_clk_en) begin
            cnt_q <= cnt_d;
        end
    end

    assign o_done = (cnt_q == W'(LIMIT));
endmodule : oscc_interval_timer
`default_nettype wire

/* src/oscc_oscillator.sv */
// Free-running jittered oscillator: cycle-start pulse and maximum-duty level.
// Assumes the 50 MHz reference clock; jitter sweeps the period up and down.
`timescale 1ns/1ns
`default_nettype none
module oscc_oscillator #(
    parameter int unsigned PW = 9
) (
    // Clock and reset.
    input wire logic i_ref_clk,
    input wire logic i_rst_n,
    input wire logic i_clk_en,
    // Control.
    input wire logic i_jit_en,
    // Oscillator outputs.
    output oscc_pkg::oscc_osc_t o_osc
);
    logic [PW-1:0] cnt_q;
    logic [PW-1:0] cnt_d;
    logic [PW-1:0] jit_q;
    logic [PW-1:0] jit_d;
    logic dir_q;
    logic dir_d;
    logic [PW-1:0] last;
    logic wrap;
    oscc_pkg::oscc_osc_t osc_q;
    oscc_pkg::oscc_osc_t osc_d;

    always_comb begin
        last = PW'(oscc_pkg::OSC_FAST_CYC - 1) + (i_jit_en ? jit_q : '0);
        wrap = (cnt_q >= last);
        cnt_d = wrap ? '0 : cnt_q + 1'b1;
        jit_d = jit_q;
        dir_d = dir_q;
        // The period walks one step per cycle across the jitter span.
        if (wrap) begin
            if (dir_q) begin
                jit_d = jit_q + 1'b1;
                dir_d = (jit_q + 1'b1) != PW'(oscc_pkg::JIT_CYC);
            end else begin
                jit_d = jit_q - 1'b1;
                dir_d = (jit_q - 1'b1) == '0;
            end
        end
        osc_d.start = wrap;
        osc_d.max_duty = cnt_d < PW'(oscc_pkg::DUTY_CYC);
    end

    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_n) begin
            cnt_q <= '0;
            jit_q <= '0;
            dir_q <= 1'b1;
            osc_q <= '0;
        end else if (i_clk_en) begin
            cnt_q <= cnt_d;
            jit_q <= jit_d;
            dir_q <= dir_d;
            osc_q <= osc_d;
        end
    end

    assign o_osc = osc_q;
endmodule : oscc_oscillator
`default_nettype wire

/* src/oscc_switch_controller.sv */
// Cycle-by-cycle on/off controller of an integrated power switch, APB slave.
// Assumes all inputs synchronous to i_ref_clk and analog sensing outside.
`timescale 1ns/1ns
`default_nettype none
module oscc_switch_controller #(
    parameter int unsigned FAULT_OSC = oscc_pkg::FAULT_OSC,
    parameter int unsigned RESTART_OSC = oscc_pkg::RESTART_OSC,
    parameter bit SMALLEST_MEMBER = 1'b0
) (
    // Clock, reset and clock enable.
    input wire logic i_ref_clk,
    input wire logic i_rst_n,
    input wire logic i_clk_en,
    // APB slave.
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [7:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    output logic [31:0] o_prdata,
    output logic o_pready,
    output logic o_pslverr,
    // Sensing.
    input wire logic i_feedback_line_sense_pin,
    input wire logic i_line_sense_present,
    input wire logic i_line_uv,
    input wire logic i_cur_limit,
    input wire logic [1:0] i_cap_class,
    // Switch and status.
    output logic o_switch_on,
    output logic o_max_duty_signal,
    output logic o_cycle_start,
    output logic [2:0] o_run_state,
    output logic [2:0] o_cl_step,
    output logic [1:0] o_cl_range
);
    localparam int unsigned CW = $clog2(oscc_pkg::CL_WIN + 1);
    localparam int unsigned OW = $clog2(oscc_pkg::MIN_ON_CYC + 1);

    oscc_pkg::oscc_osc_t osc;
    logic start;
    logic uv_active;
    logic fire;
    logic fault_done;
    logic restart_done;
    logic fault_clear;
    logic fault_tick;
    logic restart_clear;
    logic restart_tick;

    // Cycle and switch state.
    logic switch_q;
    logic switch_d;
    logic skip_q;
    logic skip_d;
    logic startup_q;
    logic startup_d;
    logic [OW-1:0] on_cnt_q;
    logic [OW-1:0] on_cnt_d;
    logic duty_q;
    logic start_q;

    // Run state machine.
    oscc_pkg::oscc_run_t st_q;
    oscc_pkg::oscc_run_t st_d;

    // Current-limit state machine.
    oscc_pkg::oscc_cl_t cl_q;
    oscc_pkg::oscc_cl_t cl_d;
    logic [CW-1:0] win_q;
    logic [CW-1:0] win_d;
    logic [CW-1:0] en_q;
    logic [CW-1:0] en_d;
    logic [CW-1:0] en_sum;

    // Current-limit range capture.
    logic cap_done_q;
    logic cap_done_d;
    logic [1:0] rng_q;
    logic [1:0] rng_d;

    // Registers and bus.
    logic [1:0] ctrl_q;
    logic [1:0] ctrl_d;
    logic [31:0] count_q;
    logic [31:0] count_d;
    logic [31:0] prdata_q;
    logic [31:0] prdata_d;
    logic pready_q;
    logic pready_d;
    logic pslverr_q;
    logic pslverr_d;
    logic setup;
    logic wr_ok;
    logic mapped;

    oscc_oscillator #(
        .PW(9)
    ) u_osc (
        .i_ref_clk(i_ref_clk),
        .i_rst_n(i_rst_n),
        .i_clk_en(i_clk_en),
        .i_jit_en(ctrl_q[oscc_pkg::CTRL_JIT_BIT]),
        .o_osc(osc)
    );

    oscc_interval_timer #(
        .LIMIT(FAULT_OSC)
    ) u_fault (
        .i_ref_clk(i_ref_clk),
        .i_rst_n(i_rst_n),
        .i_clk_en(i_clk_en),
        .i_clear(fault_clear),
        .i_tick(fault_tick),
        .o_done(fault_done)
    );

    oscc_interval_timer #(
        .LIMIT(RESTART_OSC)
    ) u_restart (
        .i_ref_clk(i_ref_clk),
        .i_rst_n(i_rst_n),
        .i_clk_en(i_clk_en),
        .i_clear(restart_clear),
        .i_tick(restart_tick),
        .o_done(restart_done)
    );

    // Switching cycle: the enable is looked at only on the cycle-start pulse.
    always_comb begin
        start = osc.start;
        uv_active = i_line_sense_present && i_line_uv;
        fire = start && i_feedback_line_sense_pin && (st_q == oscc_pkg::ST_RUN)
            && ctrl_q[oscc_pkg::CTRL_RUN_BIT] && !skip_q && !switch_q;
        switch_d = switch_q;
        on_cnt_d = on_cnt_q;
        skip_d = skip_q;
        startup_d = startup_q;
        if (start) begin
            skip_d = 1'b0;
        end
        if (fire) begin
            switch_d = 1'b1;
            on_cnt_d = '0;
        end else if (switch_q) begin
            // Only the limit or the duty end stops a running cycle.
            if (i_cur_limit || !osc.max_duty) begin
                switch_d = 1'b0;
                if (i_cur_limit && startup_q && on_cnt_q < OW'(oscc_pkg::MIN_ON_CYC)) begin
                    skip_d = 1'b1;
                end
            end else if (on_cnt_q != OW'(oscc_pkg::MIN_ON_CYC)) begin
                on_cnt_d = on_cnt_q + 1'b1;
            end
        end
        // Start-up or restart ends at the first skipped cycle.
        if (start && !i_feedback_line_sense_pin && st_q == oscc_pkg::ST_RUN) begin
            startup_d = 1'b0;
        end else if (st_q != oscc_pkg::ST_RUN) begin
            startup_d = 1'b1;
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_n) begin
            switch_q <= 1'b0;
            skip_q <= 1'b0;
            startup_q <= 1'b1;
            on_cnt_q <= '0;
            duty_q <= 1'b0;
            start_q <= 1'b0;
        end else if (i_clk_en) begin
            switch_q <= switch_d;
            skip_q <= skip_d;
            startup_q <= startup_d;
            on_cnt_q <= on_cnt_d;
            duty_q <= osc.max_duty;
            start_q <= osc.start;
        end
    end

    // Run state: undervoltage wait, running, restart-off.
    always_comb begin
        st_d = st_q;
        fault_clear = (st_q != oscc_pkg::ST_RUN) || (start && !i_feedback_line_sense_pin);
        fault_tick = start && (st_q == oscc_pkg::ST_RUN);
        restart_clear = (st_q != oscc_pkg::ST_OFF);
        restart_tick = start && (st_q == oscc_pkg::ST_OFF) && !uv_active;
        unique case (st_q)
            oscc_pkg::ST_UV_WAIT: begin
                if (!uv_active) begin
                    st_d = oscc_pkg::ST_RUN;
                end
            end
            oscc_pkg::ST_RUN: begin
                if (fault_done) begin
                    st_d = oscc_pkg::ST_OFF;
                end
            end
            oscc_pkg::ST_OFF: begin
                if (restart_done) begin
                    st_d = oscc_pkg::ST_UV_WAIT;
                end
            end
            default: begin
                st_d = oscc_pkg::ST_UV_WAIT;
            end
        endcase
    end

    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_n) begin
            st_q <= oscc_pkg::ST_UV_WAIT;
        end else if (i_clk_en) begin
            st_q <= st_d;
        end
    end

    // Load estimate: enabled cycles counted over a window of samples.
    always_comb begin
        cl_d = cl_q;
        win_d = win_q;
        en_d = en_q;
        en_sum = en_q + CW'(fire);
        if (start) begin
            if (win_q == CW'(oscc_pkg::CL_WIN - 1)) begin
                win_d = '0;
                en_d = '0;
                if (en_sum >= CW'(oscc_pkg::CL_FULL_MIN)) begin
                    cl_d = oscc_pkg::CL_FULL;
                end else if (en_sum >= CW'(oscc_pkg::CL_MED_MIN)) begin
                    cl_d = oscc_pkg::CL_MED;
                end else begin
                    cl_d = oscc_pkg::CL_LIGHT;
                end
            end else begin
                win_d = win_q + 1'b1;
                en_d = en_sum;
            end
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_n) begin
            cl_q <= oscc_pkg::CL_FULL;
            win_q <= '0;
            en_q <= '0;
        end else if (i_clk_en) begin
            cl_q <= cl_d;
            win_q <= win_d;
            en_q <= en_d;
        end
    end

    // Limit range taken from the capacitor class once, then held.
    always_comb begin
        cap_done_d = 1'b1;
        rng_d = rng_q;
        if (!cap_done_q) begin
            unique case (i_cap_class)
                oscc_pkg::CAP_MED: rng_d = oscc_pkg::RNG_RED;
                oscc_pkg::CAP_LARGE: rng_d = SMALLEST_MEMBER ? oscc_pkg::RNG_STD
                    : oscc_pkg::RNG_INC;
                default: rng_d = oscc_pkg::RNG_STD;
            endcase
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_n) begin
            cap_done_q <= 1'b0;
            rng_q <= oscc_pkg::RNG_STD;
        end else if (i_clk_en) begin
            cap_done_q <= cap_done_d;
            rng_q <= rng_d;
        end
    end

    // APB slave with one answer cycle; unmapped offsets answer with an error.
    always_comb begin
        setup = i_psel && !i_penable;
        wr_ok = i_psel && i_penable && pready_q && i_pwrite && !pslverr_q;
        mapped = (i_paddr == oscc_pkg::REG_CTRL) || (i_paddr == oscc_pkg::REG_STATUS)
            || (i_paddr == oscc_pkg::REG_COUNT);
        ctrl_d = ctrl_q;
        if (wr_ok && i_paddr == oscc_pkg::REG_CTRL) begin
            ctrl_d = i_pwdata[1:0];
        end
        count_d = fire ? count_q + 32'h1 : count_q;
        pready_d = setup;
        pslverr_d = setup && !mapped;
        prdata_d = 32'h0;
        if (setup && !i_pwrite) begin
            if (i_paddr == oscc_pkg::REG_CTRL) begin
                prdata_d = {30'h0, ctrl_q};
            end else if (i_paddr == oscc_pkg::REG_STATUS) begin
                prdata_d = {21'h0, uv_active, startup_q, switch_q, rng_q, cl_q, st_q};
            end else if (i_paddr == oscc_pkg::REG_COUNT) begin
                prdata_d = count_q;
            end
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_n) begin
            ctrl_q <= oscc_pkg::CTRL_RESET;
            count_q <= 32'h0;
            prdata_q <= 32'h0;
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
        end else if (i_clk_en) begin
            ctrl_q <= ctrl_d;
            count_q <= count_d;
            prdata_q <= prdata_d;
            pready_q <= pready_d;
            pslverr_q <= pslverr_d;
        end
    end

    assign o_prdata = prdata_q;
    assign o_pready = pready_q;
    assign o_pslverr = pslverr_q;
    assign o_switch_on = switch_q;
    assign o_max_duty_signal = duty_q;
    assign o_cycle_start = start_q;
    assign o_run_state = st_q;
    assign o_cl_step = cl_q;
    assign o_cl_range = rng_q;
endmodule : oscc_switch_controller
`default_nettype wire

/* sim/oscc_sva.sv */
// Assertion checker of the switching-cycle controller, bound to its ports.
// Assumes the clock enable stays high throughout.
`timescale 1ns/1ns
`default_nettype none
module oscc_sva #(
    parameter bit SMALLEST_MEMBER = 1'b0
) (
    // Clock, reset and bus.
    input wire logic i_ref_clk,
    input wire logic i_rst_n,
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic [7:0] i_paddr,
    input wire logic [31:0] o_prdata,
    input wire logic o_pready,
    input wire logic o_pslverr,
    // Sensing and switch.
    input wire logic i_feedback_line_sense_pin,
    input wire logic i_line_sense_present,
    input wire logic i_line_uv,
    input wire logic i_cur_limit,
    input wire logic [1:0] i_cap_class,
    input wire logic o_switch_on,
    input wire logic o_max_duty_signal,
    input wire logic o_cycle_start,
    input wire logic [2:0] o_run_state,
    input wire logic [1:0] o_cl_range
);
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (!i_rst_n);
    logic [8:0] duty_q;
    logic [8:0] duty_d;
    logic [1:0] rng;
    logic uvw;
    // Length of the current max-duty window in clocks.
    // Only windows opened by a cycle start count, since the first one after reset is partial.
    always_comb begin
        duty_d = 9'h0;
        if (o_cycle_start) begin
            duty_d = 9'h1;
        end else if (o_max_duty_signal && duty_q != 9'h0) begin
            duty_d = duty_q + 9'h1;
        end
    end
    always_ff @(posedge i_ref_clk) begin
        duty_q <= duty_d;
    end
    assign rng = (i_cap_class == oscc_pkg::CAP_MED) ? oscc_pkg::RNG_RED :
        (i_cap_class == oscc_pkg::CAP_LARGE && !SMALLEST_MEMBER) ? oscc_pkg::RNG_INC :
        oscc_pkg::RNG_STD;
    assign uvw = i_line_sense_present && i_line_uv;
    sequence s_setup;
        i_psel && !i_penable;
    endsequence
    sequence s_bad;
        s_setup ##0 (i_paddr != oscc_pkg::REG_CTRL && i_paddr != oscc_pkg::REG_STATUS &&
            i_paddr != oscc_pkg::REG_COUNT);
    endsequence
    AST_SW_CAUSE: assert property ($rose(o_switch_on) |->
        o_cycle_start && $past(i_feedback_line_sense_pin)) else $error("switch rise uncaused");
    AST_SW_END: assert property ($fell(o_switch_on) |->
        $past(i_cur_limit) || !o_max_duty_signal) else $error("switch ended early");
    AST_SW_DUTY: assert property (o_switch_on |-> o_max_duty_signal)
        else $error("switch on past duty");
    AST_DUTY_LEN: assert property ($fell(o_max_duty_signal) && duty_q != 9'h0 |->
        duty_q == 9'(oscc_pkg::DUTY_CYC)) else $error("duty length wrong");
    AST_RUN_ONLY: assert property ($rose(o_switch_on) |->
        $past(o_run_state) == oscc_pkg::ST_RUN) else $error("switch outside run");
    AST_UV_HOLD: assert property (uvw && o_run_state == oscc_pkg::ST_UV_WAIT |=>
        o_run_state == oscc_pkg::ST_UV_WAIT) else $error("left uv wait");
    AST_UV_NORUN: assert property (uvw && o_run_state != oscc_pkg::ST_RUN |=>
        o_run_state != oscc_pkg::ST_RUN) else $error("restart under uv");
    AST_RNG_HOLD: assert property ($past(i_rst_n) && $past(i_rst_n, 2) |->
        $stable(o_cl_range)) else $error("range changed");
    AST_RNG_MAP: assert property ($past(i_rst_n) |-> o_cl_range == rng)
        else $error("range map wrong");
    AST_APB_READY: assert property (s_setup |=> o_pready) else $error("pready late");
    AST_APB_ERR: assert property (s_bad |=> o_pslverr && o_prdata == 32'h0)
        else $error("no slave error");
endmodule : oscc_sva
bind oscc_switch_controller oscc_sva #(.SMALLEST_MEMBER(SMALLEST_MEMBER)) i_oscc_sva (
    .i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n), .i_psel(i_psel), .i_penable(i_penable),
    .i_paddr(i_paddr), .o_prdata(o_prdata), .o_pready(o_pready), .o_pslverr(o_pslverr),
    .i_feedback_line_sense_pin(i_feedback_line_sense_pin),
    .i_line_sense_present(i_line_sense_present), .i_line_uv(i_line_uv),
    .i_cur_limit(i_cur_limit), .i_cap_class(i_cap_class), .o_switch_on(o_switch_on),
    .o_max_duty_signal(o_max_duty_signal), .o_cycle_start(o_cycle_start),
    .o_run_state(o_run_state), .o_cl_range(o_cl_range));
`default_nettype wire

/* sim/oscc_fb_model.sv */
// Behavioural secondary-side feedback driving the enable input.
// Assumes the switch and cycle-start outputs of the controller.
`timescale 1ns/1ns
`default_nettype none
module oscc_fb_model (
    // Clock and reset.
    input wire logic i_ref_clk,
    input wire logic i_rst_n,
    // Controller side and mode.
    input wire logic i_switch_on,
    input wire logic i_cycle_start,
    input wire logic [1:0] i_mode,
    input wire logic [4:0] i_k,
    output logic o_fb
);
    int lvl;
    int idx;
    // Output charges while the switch conducts; the load drains it.
    always @(posedge i_ref_clk) begin
        if (!i_rst_n) begin
            lvl <= 0;
            idx <= 0;
        end else begin
            lvl <= i_switch_on ? lvl + 4 : (lvl > 0 ? lvl - 1 : 0);
            if (i_cycle_start) begin
                idx <= (idx + 1) % 16;
            end
        end
    end
    // Mode 1 is an open loop, mode 2 enables i_k periods out of 16.
    always_comb begin
        case (i_mode)
            2'h1: o_fb = 1'b1;
            2'h2: o_fb = idx < int'(i_k);
            default: o_fb = lvl < 400;
        endcase
    end
endmodule : oscc_fb_model
`default_nettype wire

/* sim/tb_top.sv */
// Self-checking bench of the switching-cycle controller.
// Assumes the feedback model on the enable input; clock enable held high.
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin n_errors++; \
    $display("CHECK FAILED %s exp %0h got %0h", nm, e, g); end end
module tb_top;
    localparam int unsigned FO = 20;
    localparam int unsigned RO = 30;
    logic clk = 1'b0, rst_n = 1'b0, psel = 1'b0, pen = 1'b0, pwr = 1'b0;
    logic [7:0] paddr = 8'h0;
    logic [31:0] pwdata = 32'h0, prdata;
    logic pready, pslverr, fb, sw, md, cs, short_cl = 1'b0;
    logic sense = 1'b0, uv = 1'b0, cl = 1'b0, last_sw = 1'b0;
    logic [1:0] cap = 2'h0, rng, mode = 2'h1;
    logic [2:0] rs, step;
    logic [4:0] k = 5'h0;
    logic [31:0] seed = 32'ha608;
    int n_errors = 0, cmp_count = 0, n_cs = 0, n_sw = 0, n_dbl = 0, on_n = 0, lim = 0;
    int s0_tab[3] = '{3, 2, 8};
    oscc_switch_controller #(.FAULT_OSC(FO), .RESTART_OSC(RO), .SMALLEST_MEMBER(1'b0))
    i_oscc_switch_controller (.i_ref_clk(clk), .i_rst_n(rst_n), .i_clk_en(1'b1),
        .i_psel(psel), .i_penable(pen), .i_pwrite(pwr), .i_paddr(paddr), .i_pwdata(pwdata),
        .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
        .i_feedback_line_sense_pin(fb), .i_line_sense_present(sense), .i_line_uv(uv),
        .i_cur_limit(cl), .i_cap_class(cap), .o_switch_on(sw), .o_max_duty_signal(md),
        .o_cycle_start(cs), .o_run_state(rs), .o_cl_step(step), .o_cl_range(rng));
    oscc_fb_model i_oscc_fb_model (.i_ref_clk(clk), .i_rst_n(rst_n), .i_switch_on(sw),
        .i_cycle_start(cs), .i_mode(mode), .i_k(k), .o_fb(fb));
    initial forever #10 clk = ~clk;
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    function automatic oscc_pkg::oscc_cl_t exp_step(int n);
        if (n >= oscc_pkg::CL_FULL_MIN) return oscc_pkg::CL_FULL;
        return n >= oscc_pkg::CL_MED_MIN ? oscc_pkg::CL_MED : oscc_pkg::CL_LIGHT;
    endfunction
    // Current sense: short pulses end below the minimum on-time, long ones may outlast duty.
    always @(posedge clk) begin
        if (!sw) begin
            on_n <= 0;
            cl <= 1'b0;
            lim <= short_cl ? 5 : 25 + int'(rnd() % 300);
        end else begin
            on_n <= on_n + 1;
            cl <= on_n + 2 >= lim;
        end
        if (cs) begin
            n_cs <= n_cs + 1;
            n_sw <= n_sw + int'(sw);
            n_dbl <= n_dbl + int'(sw && last_sw);
            last_sw <= sw;
        end else if (!rst_n) begin
            last_sw <= 1'b0;
        end
    end
    task automatic do_reset(logic [1:0] c, logic s, logic u);
        rst_n <= 1'b0;
        cap <= c;
        sense <= s;
        uv <= u;
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        // The range is captured on the first edge after release and read one edge later.
        repeat (2) @(posedge clk);
    endtask : do_reset
    task automatic apb(logic w, logic [7:0] a, logic [31:0] d, output logic [31:0] r,
        output logic e);
        psel <= 1'b1;
        pwr <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        pen <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1) @(posedge clk);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        pen <= 1'b0;
        @(posedge clk);
    endtask : apb
    task automatic starts(int n);
        int c;
        c = n_cs + n;
        while (n_cs < c) @(posedge clk);
    endtask : starts
    task automatic wait_rs(logic [2:0] s, int per);
        int t;
        t = 0;
        while (rs !== s && t < per * 400) begin
            @(posedge clk);
            t++;
        end
        `CHK("run_state", s, rs)
    endtask : wait_rs
    task automatic close_out();
        $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : close_out
    initial begin
        #2_100_000;
        n_errors++;
        close_out();
    end
    initial begin
        logic [31:0] r;
        logic e;
        int s0;
        mode <= 2'h0;
        do_reset(oscc_pkg::CAP_MED, 1'b0, 1'b0);
        `CHK("range", oscc_pkg::RNG_RED, rng)
        apb(1'b0, oscc_pkg::REG_CTRL, 32'h0, r, e);
        `CHK("ctrl reset", 32'h3, r)
        apb(1'b0, 8'h0c, 32'h0, r, e);
        `CHK("unmapped", 1'b1, e)
        apb(1'b1, oscc_pkg::REG_CTRL, 32'h1, r, e);
        apb(1'b0, oscc_pkg::REG_CTRL, 32'h0, r, e);
        `CHK("ctrl", 32'h1, r)
        apb(1'b0, oscc_pkg::REG_STATUS, 32'h0, r, e);
        `CHK("status range", oscc_pkg::RNG_RED, r[7:6])
        s0 = n_sw;
        starts(6);
        `CHK("switching", 1'b1, n_sw > s0)
        apb(1'b0, oscc_pkg::REG_COUNT, 32'h0, r, e);
        `CHK("count", 32'(n_sw - s0), r)
        mode <= 2'h1;
        short_cl <= 1'b1;
        do_reset(oscc_pkg::CAP_LARGE, 1'b0, 1'b0);
        `CHK("range", oscc_pkg::RNG_INC, rng)
        s0 = n_dbl;
        starts(8);
        `CHK("skip after short", s0, n_dbl)
        short_cl <= 1'b0;
        wait_rs(oscc_pkg::ST_OFF, FO + 2);
        s0 = n_cs;
        wait_rs(oscc_pkg::ST_RUN, RO + 4);
        `CHK("off time", 1'b1, n_cs - s0 >= RO - 1 && n_cs - s0 <= RO + 1)
        do_reset(oscc_pkg::CAP_MIN, 1'b1, 1'b1);
        `CHK("range", oscc_pkg::RNG_STD, rng)
        s0 = n_sw;
        starts(4);
        `CHK("uv wait", oscc_pkg::ST_UV_WAIT, rs)
        `CHK("uv switches", s0, n_sw)
        uv <= 1'b0;
        wait_rs(oscc_pkg::ST_RUN, 2);
        uv <= 1'b1;
        s0 = n_sw;
        wait_rs(oscc_pkg::ST_OFF, FO + 2);
        `CHK("fault span", 1'b1, n_sw - s0 >= FO - 1 && n_sw - s0 <= FO + 1)
        starts(RO + 2);
        `CHK("no restart", 1'b0, rs === oscc_pkg::ST_RUN)
        uv <= 1'b0;
        wait_rs(oscc_pkg::ST_RUN, RO + 4);
        mode <= 2'h2;
        foreach (s0_tab[i]) begin
            k <= 5'(s0_tab[i]);
            starts(33);
            `CHK("cl step", exp_step(s0_tab[i]), step)
        end
        close_out();
    end
endmodule : tb_top
`default_nettype wire
